// ### rtl/power_mode_pkg.sv
// Package of constants and types for the power mode controller.
// Assumes an 8-bit special function register bus from the CPU core.

package power_mode_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
  localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
  localparam int IDLE_BIT = 0;
  localparam int STOP_BIT = 1;
  localparam int FLAGS_LSB = 2;
  localparam int FLAGS_WIDTH = 6;
  localparam int SUSPEND_BIT = 5;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 50;
  localparam int OSC_SETTLE_NS = 2000;
  localparam int OSC_SETTLE_CYCLES = (OSC_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_PULSE_CYCLES = 4;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [4:0] {
    ST_RUN     = 5'b00001,
    ST_IDLE    = 5'b00010,
    ST_STOP    = 5'b00100,
    ST_SUSPEND = 5'b01000,
    ST_WAKE    = 5'b10000
  } power_state_t;

  typedef struct packed {
    logic port_match;
    logic timer3_overflow;
    logic comparator_low;
    logic comparator_wake_en;
  } wake_events_t;

  typedef struct packed {
    logic cpu_clock_en;
    logic periph_clock_en;
    logic hf_osc_en;
    logic regulator_en;
    logic timer3_run;
    logic port_match_run;
    logic mcd_run;
  } power_ctrl_t;

endpackage

// ### rtl/reset_pulse.sv
// Stretches a reset request into a core reset pulse held CYCLES cycles past the request.
// Assumes requests are on clk.
`timescale 1ns/1ps
module reset_pulse
  import power_mode_pkg::*;
#(
  parameter int CYCLES = RESET_PULSE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request and pulse
  input wire logic request,
  output logic core_reset
);
  import power_mode_pkg::*;

  logic [7:0] count_reg;

  // ****************************************
  // Pulse counter
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= 8'h00;
    end else if (request) begin
      count_reg <= 8'(CYCLES);
    end else if (count_reg != 8'h00) begin
      count_reg <= count_reg - 8'h01;
    end
  end

  assign core_reset = rst || (count_reg != 8'h00);
endmodule

// ### rtl/settle_timer.sv
// Counts oscillator settling time after a restart.
// Assumes start is a one-cycle pulse on clk.
`timescale 1ns/1ps
module settle_timer
  import power_mode_pkg::*;
#(
  parameter int CYCLES = OSC_SETTLE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic start,
  output logic done
);
  import power_mode_pkg::*;

  logic [15:0] count_reg;
  logic busy_reg;

  // ****************************************
  // Settle counter
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= 16'h0000;
      busy_reg <= 1'b0;
    end else if (start) begin
      count_reg <= 16'(CYCLES - 1);
      busy_reg <= 1'b1;
    end else if (busy_reg) begin
      if (count_reg == 16'h0000) begin
        busy_reg <= 1'b0;
      end else begin
        count_reg <= count_reg - 16'h0001;
      end
    end
  end

  assign done = busy_reg && (count_reg == 16'h0000);
endmodule

// ### rtl/power_mode_controller.sv
// Power mode controller: idle, stop and suspend sequencing with wake logic.
// Assumes CPU gives instruction-complete strobe; external pins arrive asynchronous.
`timescale 1ns/1ps
module power_mode_controller
  import power_mode_pkg::*;
#(
  parameter int SETTLE_CYCLES = OSC_SETTLE_CYCLES,
  parameter int PULSE_CYCLES = RESET_PULSE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Special function register bus
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_write,
  input wire logic sfr_read,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  // Suspend request from oscillator control write
  input wire logic suspend_write,
  // CPU status
  input wire logic instr_done,
  input wire logic irq_pending,
  // Reset sources
  input wire logic reset_pin_n,
  input wire logic watchdog_reset,
  input wire logic watchdog_enable,
  input wire logic mcd_timeout,
  input wire logic mcd_enable,
  input wire logic other_reset,
  input wire logic regulator_off_in_halt,
  // Wake sources
  input wire power_mode_pkg::wake_events_t wake_in,
  input wire logic timer3_slow_clock,
  input wire logic port_match_irq_en,
  input wire logic timer3_irq_en,
  // Power control outputs
  output power_mode_pkg::power_ctrl_t power_ctrl,
  output logic core_reset,
  output logic [15:0] fetch_addr_on_reset,
  output logic service_wake_irq,
  output logic suspend_clear,
  output logic [1:0] mode_status
);
  import power_mode_pkg::*;

  power_state_t state_reg;
  power_state_t state_next;
  logic [FLAGS_WIDTH-1:0] flags_reg;
  logic idle_pend_reg;
  logic stop_pend_reg;
  logic susp_pend_reg;
  logic reg_off_reg;
  logic [2:0] pin_sync1_reg;
  logic [2:0] pin_sync2_reg;
  logic [1:0] rst_sync1_reg;
  logic [1:0] rst_sync2_reg;
  logic port_match_s;
  logic timer3_s;
  logic comp_low_s;
  logic reset_pin_s;
  logic any_reset;
  logic suspend_wake;
  logic settle_done;
  logic wake_pm_reg;
  logic wake_t3_reg;
  logic irq_req_reg;
  logic suspend_clear_reg;
  logic [7:0] rdata_reg;

  function automatic logic addr_hit(input logic [7:0] addr);
    addr_hit = (addr == POWER_CONTROL_ADDR);
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_sync1_reg <= 3'h0;
      pin_sync2_reg <= 3'h0;
      rst_sync1_reg <= 2'h0;
      rst_sync2_reg <= 2'h0;
    end else begin
      pin_sync1_reg <= {wake_in.port_match, wake_in.timer3_overflow, wake_in.comparator_low};
      pin_sync2_reg <= pin_sync1_reg;
      rst_sync1_reg <= {~reset_pin_n, mcd_timeout};
      rst_sync2_reg <= rst_sync1_reg;
    end
  end

  assign port_match_s = pin_sync2_reg[2];
  assign timer3_s = pin_sync2_reg[1] && timer3_slow_clock;
  assign comp_low_s = pin_sync2_reg[0] && wake_in.comparator_wake_en;
  assign reset_pin_s = rst_sync2_reg[1];

  // ****************************************
  // Reset merging
  // ****************************************
  always_comb begin
    if (reg_off_reg && state_reg == ST_STOP) begin
      any_reset = reset_pin_s;
    end else begin
      any_reset = reset_pin_s || other_reset
        || (watchdog_enable && watchdog_reset)
        || (mcd_enable && rst_sync2_reg[0]);
    end
  end

  // ****************************************
  // Core reset pulse
  // ****************************************
  reset_pulse #(
    .CYCLES(PULSE_CYCLES)
  ) reset_pulse_i (
    .clk(clk),
    .rst(rst),
    .request(any_reset),
    .core_reset(core_reset)
  );

  // ****************************************
  // Reset vector
  // ****************************************
  assign fetch_addr_on_reset = RESET_VECTOR;

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst || any_reset) begin
      flags_reg <= POWER_CONTROL_RESET[FLAGS_LSB +: FLAGS_WIDTH];
    end else if (sfr_write && addr_hit(sfr_addr)) begin
      flags_reg <= sfr_wdata[FLAGS_LSB +: FLAGS_WIDTH];
    end
  end

  // ****************************************
  // Pending mode requests
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst || any_reset) begin
      idle_pend_reg <= 1'b0;
      stop_pend_reg <= 1'b0;
      susp_pend_reg <= 1'b0;
    end else if (instr_done) begin
      idle_pend_reg <= 1'b0;
      stop_pend_reg <= 1'b0;
      susp_pend_reg <= 1'b0;
    end else begin
      if (sfr_write && addr_hit(sfr_addr) && sfr_wdata[IDLE_BIT]) begin
        idle_pend_reg <= 1'b1;
      end
      if (sfr_write && addr_hit(sfr_addr) && sfr_wdata[STOP_BIT]) begin
        stop_pend_reg <= 1'b1;
      end
      if (suspend_write) begin
        susp_pend_reg <= 1'b1;
      end
    end
  end

  // ****************************************
  // Regulator-off latch
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst || any_reset) begin
      reg_off_reg <= 1'b0;
    end else if (state_reg == ST_RUN && instr_done && stop_pend_reg) begin
      reg_off_reg <= regulator_off_in_halt;
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (sfr_read && addr_hit(sfr_addr)) begin
      rdata_reg <= {flags_reg, 1'b0, 1'b0};
    end
  end

  assign sfr_rdata = rdata_reg;
  assign sfr_hit = addr_hit(sfr_addr);

  // ****************************************
  // Mode state machine
  // ****************************************
  assign suspend_wake = port_match_s || timer3_s || comp_low_s;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RUN: begin
        if (instr_done && stop_pend_reg) begin
          state_next = ST_STOP;
        end else if (instr_done && susp_pend_reg) begin
          state_next = ST_SUSPEND;
        end else if (instr_done && idle_pend_reg) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (irq_pending) begin
          state_next = ST_RUN;
        end
      end
      ST_STOP: begin
        state_next = ST_STOP;
      end
      ST_SUSPEND: begin
        if (suspend_wake) begin
          state_next = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (settle_done) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst || any_reset) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Oscillator settle timer
  // ****************************************
  settle_timer #(
    .CYCLES(SETTLE_CYCLES)
  ) settle_timer_i (
    .clk(clk),
    .rst(rst),
    .start(state_reg == ST_SUSPEND && suspend_wake),
    .done(settle_done)
  );

  // ****************************************
  // Wake interrupt and suspend clear
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst || any_reset) begin
      wake_pm_reg <= 1'b0;
      wake_t3_reg <= 1'b0;
    end else if (state_reg == ST_SUSPEND && suspend_wake) begin
      wake_pm_reg <= port_match_s;
      wake_t3_reg <= timer3_s;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || any_reset) begin
      irq_req_reg <= 1'b0;
      suspend_clear_reg <= 1'b0;
    end else begin
      irq_req_reg <= state_reg == ST_WAKE && settle_done
        && ((wake_pm_reg && port_match_irq_en) || (wake_t3_reg && timer3_irq_en));
      suspend_clear_reg <= state_reg == ST_WAKE && settle_done;
    end
  end

  assign service_wake_irq = irq_req_reg;
  assign suspend_clear = suspend_clear_reg;

  // ****************************************
  // Clock and power gating
  // ****************************************
  always_comb begin
    power_ctrl.cpu_clock_en = (state_reg == ST_RUN);
    power_ctrl.periph_clock_en = (state_reg == ST_RUN) || (state_reg == ST_IDLE);
    power_ctrl.hf_osc_en = (state_reg != ST_STOP) && (state_reg != ST_SUSPEND);
    power_ctrl.regulator_en = !(state_reg == ST_STOP && reg_off_reg);
    power_ctrl.timer3_run = (state_reg != ST_STOP)
      && ((state_reg != ST_SUSPEND) || timer3_slow_clock);
    power_ctrl.port_match_run = (state_reg != ST_STOP);
    power_ctrl.mcd_run = mcd_enable;
  end

  // ****************************************
  // Mode status encoding
  // ****************************************
  always_comb begin
    unique case (state_reg)
      ST_IDLE: mode_status = 2'h1;
      ST_STOP: mode_status = 2'h2;
      ST_SUSPEND, ST_WAKE: mode_status = 2'h3;
      default: mode_status = 2'h0;
    endcase
  end
endmodule

// ### dv/power_mode_controller_props.sv
// Checker for the power mode controller ports.
// Assumes binding into power_mode_controller, one clock domain.
`timescale 1ns/1ps
module power_mode_controller_props
  import power_mode_pkg::*;
#(
  parameter int PULSE_CYCLES = RESET_PULSE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_write,
  input wire logic sfr_read,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  // Status and control
  input wire logic irq_pending,
  input wire power_mode_pkg::power_ctrl_t power_ctrl,
  input wire logic core_reset,
  input wire logic [15:0] fetch_addr_on_reset,
  input wire logic suspend_clear,
  input wire logic [1:0] mode_status
);
  import power_mode_pkg::*;
  // ****************************************
  // Helper logic
  // ****************************************
  logic [5:0] flags_reg;
  logic [5:0] exp_reg;
  logic ok_reg;
  logic chk_reg;
  logic rd_reg;
  logic [7:0] hi_cnt_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      flags_reg <= 6'h00;
      ok_reg <= 1'b1;
    end else if (sfr_write && sfr_hit) begin
      flags_reg <= sfr_wdata[7:2];
      ok_reg <= 1'b1;
    end else if (core_reset) begin
      ok_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    rd_reg <= !rst && sfr_read && sfr_hit;
    chk_reg <= !rst && sfr_read && sfr_hit && ok_reg;
    exp_reg <= flags_reg;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      hi_cnt_reg <= 8'hFF;
    end else if (!core_reset) begin
      hi_cnt_reg <= 8'h00;
    end else if (hi_cnt_reg != 8'hFF) begin
      hi_cnt_reg <= hi_cnt_reg + 8'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ****************************************
  // Assertions
  // ****************************************
  a_idle_clocks: assert property (
    mode_status == 2'd1 |-> !power_ctrl.cpu_clock_en && power_ctrl.periph_clock_en)
    else $error("idle clock gating wrong");
  a_idle_wake: assert property (
    mode_status == 2'd1 && irq_pending |=> mode_status == 2'd0)
    else $error("idle not left on interrupt");
  a_stop_gated: assert property (
    mode_status == 2'd2 |-> !power_ctrl.cpu_clock_en && !power_ctrl.hf_osc_en
      && !power_ctrl.periph_clock_en && !power_ctrl.timer3_run)
    else $error("stop mode leaves logic running");
  a_stop_exit: assert property (
    mode_status == 2'd2 ##1 mode_status != 2'd2 |-> ##[0:1] core_reset)
    else $error("stop left without reset");
  a_reset_vector: assert property (
    fetch_addr_on_reset == RESET_VECTOR)
    else $error("reset fetch address wrong");
  a_reset_length: assert property (
    $fell(core_reset) |-> hi_cnt_reg >= PULSE_CYCLES)
    else $error("core reset pulse too short");
  a_suspend_halt: assert property (
    mode_status == 2'd3 |-> !power_ctrl.cpu_clock_en)
    else $error("cpu clock on in suspend");
  a_wake_settled: assert property (
    suspend_clear |-> $past(power_ctrl.hf_osc_en, 2) && !$past(power_ctrl.cpu_clock_en, 2))
    else $error("cpu resumed before oscillator settled");
  a_flags_readback: assert property (
    chk_reg |-> sfr_rdata[7:2] == exp_reg)
    else $error("flag read back wrong");
  a_mode_bits_zero: assert property (
    rd_reg |-> sfr_rdata[1:0] == 2'b00)
    else $error("mode select bits read nonzero");
  a_run_regulator: assert property (
    mode_status == 2'd0 |-> power_ctrl.regulator_en)
    else $error("regulator off in run");
endmodule

bind power_mode_controller power_mode_controller_props #(.PULSE_CYCLES(PULSE_CYCLES))
  power_mode_controller_props_i (.clk(clk), .rst(rst), .sfr_wdata(sfr_wdata),
  .sfr_write(sfr_write), .sfr_read(sfr_read), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
  .irq_pending(irq_pending), .power_ctrl(power_ctrl), .core_reset(core_reset),
  .fetch_addr_on_reset(fetch_addr_on_reset), .suspend_clear(suspend_clear),
  .mode_status(mode_status));

// ### dv/cpu_core_model.sv
// CPU core model driving the register bus and instruction strobes.
// Assumes signals change at the falling edge of clk.
`timescale 1ns/1ps
module cpu_core_model
  import power_mode_pkg::*;
(
  // Clock
  input wire logic clk,
  // Register bus
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  output logic sfr_write,
  output logic sfr_read,
  input wire logic [7:0] sfr_rdata,
  // Instruction status
  output logic suspend_write,
  output logic instr_done
);
  import power_mode_pkg::*;
  initial begin
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_write = 1'b0;
    sfr_read = 1'b0;
    suspend_write = 1'b0;
    instr_done = 1'b0;
  end
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_write = 1'b1;
    @(negedge clk);
    sfr_write = 1'b0;
    sfr_wdata = ~d;
  endtask
  task automatic sfr_rd(output logic [7:0] d);
    @(negedge clk);
    sfr_addr = POWER_CONTROL_ADDR;
    sfr_read = 1'b1;
    @(negedge clk);
    sfr_read = 1'b0;
    d = sfr_rdata;
  endtask
  // Mode request, one-byte register read as the next instruction, then completion
  task automatic enter(input logic susp, input logic [7:0] d, output logic [7:0] rd);
    if (susp) begin
      @(negedge clk);
      suspend_write = 1'b1;
      @(negedge clk);
      suspend_write = 1'b0;
    end else begin
      sfr_wr(POWER_CONTROL_ADDR, d);
    end
    sfr_rd(rd);
    instr_done = 1'b1;
    @(negedge clk);
    instr_done = 1'b0;
  endtask
endmodule

// ### dv/power_mode_controller_tb.sv
// Self-checking bench for the power mode controller.
// Assumes the cpu_core_model partner and the bound checker.
`timescale 1ns/1ps
module power_mode_controller_tb;
  import power_mode_pkg::*;
  logic clk = 1'b0, rst = 1'b1, sfr_write, sfr_read, sfr_hit, suspend_write, instr_done;
  logic irq_pending = 1'b0, reset_pin_n = 1'b1, watchdog_reset = 1'b0;
  logic watchdog_enable = 1'b0, mcd_timeout = 1'b0, mcd_enable = 1'b0, other_reset = 1'b0;
  logic regulator_off_in_halt = 1'b0, timer3_slow_clock = 1'b1;
  logic port_match_irq_en = 1'b0, timer3_irq_en = 1'b0, core_reset, service_wake_irq;
  logic suspend_clear;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd, f;
  logic [15:0] fetch_addr_on_reset;
  logic [1:0] mode_status;
  wake_events_t wake_in = 4'h0;
  power_ctrl_t power_ctrl;
  int error_cnt = 0, tests_run = 0, cycles = 0, n;
  int irq_cnt = 0, irq_base = 0;
  always #10 clk = ~clk;
  power_mode_controller #(.SETTLE_CYCLES(2)) power_mode_controller_i (.clk(clk), .rst(rst),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_write(sfr_write), .sfr_read(sfr_read),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .suspend_write(suspend_write),
    .instr_done(instr_done), .irq_pending(irq_pending), .reset_pin_n(reset_pin_n),
    .watchdog_reset(watchdog_reset), .watchdog_enable(watchdog_enable),
    .mcd_timeout(mcd_timeout), .mcd_enable(mcd_enable), .other_reset(other_reset),
    .regulator_off_in_halt(regulator_off_in_halt), .wake_in(wake_in),
    .timer3_slow_clock(timer3_slow_clock), .port_match_irq_en(port_match_irq_en),
    .timer3_irq_en(timer3_irq_en), .power_ctrl(power_ctrl), .core_reset(core_reset),
    .fetch_addr_on_reset(fetch_addr_on_reset), .service_wake_irq(service_wake_irq),
    .suspend_clear(suspend_clear), .mode_status(mode_status));
  cpu_core_model cpu_core_model_i (.clk(clk), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_write(sfr_write), .sfr_read(sfr_read), .sfr_rdata(sfr_rdata),
    .suspend_write(suspend_write), .instr_done(instr_done));
  always @(posedge clk) begin
    if (service_wake_irq === 1'b1) irq_cnt <= irq_cnt + 1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_sig(input int which, input logic lvl);
    n = 0;
    while (n < 60 && (which == 0 ? core_reset : which == 1 ? suspend_clear
      : mode_status == 2'd0) !== lvl) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    void'($urandom(32'h3A0D));
    repeat (12) @(negedge clk);
    rst = 1'b0;
    cpu_core_model_i.sfr_rd(rd);
    check(rd, POWER_CONTROL_RESET);
    for (int i = 0; i < 8; i++) begin
      f = (i == 0) ? 8'hFC : (8'($urandom) & 8'hFC);
      cpu_core_model_i.sfr_wr(POWER_CONTROL_ADDR, f);
      cpu_core_model_i.sfr_wr(8'h88, ~f);
      check(sfr_hit, 1'b0);
      cpu_core_model_i.sfr_rd(rd);
      check(rd, f);
    end
    $display("Test register done");
    cpu_core_model_i.enter(1'b0, f | 8'h01, rd);
    check(rd, f);
    check(mode_status, 2'd1);
    check({power_ctrl.cpu_clock_en, power_ctrl.periph_clock_en}, 2'b01);
    repeat (5) @(negedge clk);
    irq_pending = 1'b1;
    wait_sig(2, 1'b1);
    irq_pending = 1'b0;
    check(mode_status, 2'd0);
    cpu_core_model_i.sfr_rd(rd);
    check(rd, f);
    watchdog_enable = 1'b1;
    cpu_core_model_i.enter(1'b0, 8'h01, rd);
    check(mode_status, 2'd1);
    watchdog_reset = 1'b1;
    wait_sig(0, 1'b1);
    watchdog_reset = 1'b0;
    check(core_reset, 1'b1);
    check(fetch_addr_on_reset, RESET_VECTOR);
    wait_sig(0, 1'b0);
    check(mode_status, 2'd0);
    $display("Test idle done");
    for (int r = 0; r < 2; r++) begin
      regulator_off_in_halt = r[0];
      mcd_enable = 1'b1;
      cpu_core_model_i.enter(1'b0, 8'h02, rd);
      check(rd, 8'h00);
      check(mode_status, 2'd2);
      check(power_ctrl.regulator_en, !r[0]);
      check({power_ctrl.timer3_run, power_ctrl.mcd_run}, 2'b01);
      irq_pending = 1'b1;
      wake_in = 4'hF;
      mcd_timeout = r[0];
      repeat (20) @(negedge clk);
      check(mode_status, 2'd2);
      irq_pending = 1'b0;
      wake_in = 4'h0;
      mcd_timeout = !r[0];
      reset_pin_n = !r[0];
      wait_sig(0, 1'b1);
      check(core_reset, 1'b1);
      mcd_timeout = 1'b0;
      reset_pin_n = 1'b1;
      wait_sig(0, 1'b0);
      check(mode_status, 2'd0);
    end
    $display("Test stop done");
    for (int s = 0; s < 3; s++) begin
      port_match_irq_en = 1'($urandom);
      timer3_irq_en = 1'($urandom);
      cpu_core_model_i.enter(1'b1, 8'h00, rd);
      check(mode_status, 2'd3);
      check({power_ctrl.hf_osc_en, power_ctrl.port_match_run}, 2'b01);
      check(power_ctrl.timer3_run, timer3_slow_clock);
      irq_base = irq_cnt;
      wake_in = (s == 0) ? 4'b1000 : (s == 1) ? 4'b0100 : 4'b0011;
      wait_sig(1, 1'b1);
      check(suspend_clear, 1'b1);
      @(negedge clk);
      wake_in = 4'h0;
      check(mode_status, 2'd0);
      check(16'(irq_cnt - irq_base), s == 0 ? port_match_irq_en : s == 1 && timer3_irq_en);
    end
    $display("Test suspend done");
    wrap_up();
  end
endmodule
